// ==== logic/uart_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the async serial block
// Assumes: 24 MHz system clock, 32-bit plain register port
// Notes: Definitions only
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH
`define OFS_MODE 8'h00
`define OFS_INTDIV 8'h04
`define OFS_FRAC 8'h08
`define OFS_CFG 8'h0c
`define OFS_DATA 8'h10
`define OFS_STAT 8'h14
`define MODE_ASYNC 2'h1
`define CFG_RTS 0
`define CFG_8BIT 1
`define CFG_2STP 2
`define CFG_PAR 3
`define CFG_ODD 4
`define CFG_FLOW 5
`define CFG_AUTO 6
`define INTDIV_RESET 16'h0068
`define INTDIV_MIN 16'h0008
`define FIFO_DEPTH 3'h4
`define RTS_ROOM 3'h2
`define FILTER_LEN 3'h3
`endif

// ==== logic/uart_pkg.sv ====
// Purpose: Types of the async serial block
// Assumes: Nothing
// Notes: Shared by the design and the bench
package uart_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } rx_state_e;
endpackage : uart_pkg

// ==== logic/serial_uart_frame_baud.sv ====
// Purpose: Async serial transmitter and receiver with fractional bit-rate generator
// Assumes: Registers on a plain strobe port; read data one cycle after the read strobe
// Notes: Bit period is 2N cycles of the system clock, plus one on alternate bits when F is set; status word shows fifo levels, busy and overrun
// Contract
// RULE1: Block runs only while mode register holds 1.
// RULE2: Bit clock is system clock divided by 2N+F; the code divides by 2N and adds the one clock of F on alternate bits only.
// RULE3: N from integer divisor register, F from fraction register.
// RULE4: Software keeps N at 8 or above.
// RULE5: Divisor range covers 300 bps up to 921.6 kbps.
// RULE6: N=104,F=0 gives 115200; N=312,F=1 gives 38400 nominally.
// RULE7: Width bit clear gives 7 data bits, set gives 8.
// RULE8: Transmitter sends one stop bit, or two when selected.
// RULE9: Receiver needs only one stop bit.
// RULE10: Parity bit present in both directions only when enabled.
// RULE11: Even parity is XOR of data, odd its inverse.
// RULE12: Frame is start, data LSB first, parity, stop bits.
// RULE13: Frame spans 9 to 12 bit periods.
// RULE14: Lines idle high; start bit is low.
// RULE15: Receiver rejects short low glitches as false starts.
// RULE16: Receiver flags parity and framing errors.
// RULE17: Request output means room to receive; clear input gates sending.
// RULE18: Handshake pins matter only with flow control enabled.
// RULE19: With flow, new character starts only while clear is low.
// RULE20: Auto request is low while receive buffer has room for two.
// RULE21: Without auto, request level follows a software bit.
// RULE22: Transmit and receive buffers hold four characters each.
// RULE23: Receiver samples bit centres, resynchronising on each start edge.
// RULE24: Fraction bit lengthens alternate bit periods by one clock.
`timescale 1ns/1ps
`default_nettype none
`include "uart_defs.svh"
module serial_uart_frame_baud
  import uart_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] address,
  input wire logic [31:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [31:0] read_data,
  output logic serial_tx,
  input wire logic serial_rx,
  output logic request_to_send_n,
  input wire logic clear_to_send_n
);
  logic [1:0] serial_mode_select;
  logic [15:0] bitrate_integer_divisor;
  logic bitrate_fraction_divisor;
  logic [6:0] async_frame_config;
  logic [7:0] tx_mem [4];
  logic [1:0] tx_wp, tx_rp;
  logic [2:0] tx_cnt;
  logic [9:0] rx_mem [4];
  logic [1:0] rx_wp, rx_rp;
  logic [2:0] rx_cnt;
  logic overrun;
  tx_state_e tx_state;
  logic [16:0] tx_tick;
  logic tx_alt;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  logic tx_second_stop;
  rx_state_e rx_state;
  logic [16:0] rx_tick;
  logic rx_alt;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_par_err;
  logic [2:0] rx_low;
  logic enabled, eight_data_bits_sel, two_stop_bits_sel, parity_enable_bit, odd_parity_sel;
  logic handshake_enable, auto_request_enable, soft_request_level;
  logic wr_data, rd_data, tx_pop, rx_push, rx_full_drop;
  logic tx_end, rx_end;

  assign enabled = serial_mode_select == `MODE_ASYNC; // see RULE1
  assign eight_data_bits_sel = async_frame_config[`CFG_8BIT];
  assign two_stop_bits_sel = async_frame_config[`CFG_2STP];
  assign parity_enable_bit = async_frame_config[`CFG_PAR];
  assign odd_parity_sel = async_frame_config[`CFG_ODD];
  assign handshake_enable = async_frame_config[`CFG_FLOW];
  assign auto_request_enable = async_frame_config[`CFG_AUTO];
  assign soft_request_level = async_frame_config[`CFG_RTS];

  // Length of one bit: 2N, plus one on alternate bits when F is set
  function automatic logic [16:0] bit_len(input logic alt);
    bit_len = {bitrate_integer_divisor, 1'b0} + {16'h0000, bitrate_fraction_divisor & alt}; // see RULE2 see RULE24
  endfunction : bit_len

  // Parity over 7 or 8 data bits
  function automatic logic parity_of(input logic [7:0] d);
    parity_of = ^(eight_data_bits_sel ? d : {1'b0, d[6:0]}) ^ odd_parity_sel; // see RULE11
  endfunction : parity_of

  assign wr_data = write_strobe && address == `OFS_DATA;
  assign rd_data = read_strobe && address == `OFS_DATA;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      serial_mode_select <= 2'h0;
      bitrate_integer_divisor <= `INTDIV_RESET; // see RULE6
      bitrate_fraction_divisor <= 1'b0;
      async_frame_config <= 7'h00;
    end else if (write_strobe) begin
      unique case (address)
        `OFS_MODE: serial_mode_select <= write_data[1:0];
        `OFS_INTDIV: bitrate_integer_divisor <= write_data[15:0]; // see RULE3 see RULE5
        `OFS_FRAC: bitrate_fraction_divisor <= write_data[0]; // see RULE3
        `OFS_CFG: async_frame_config <= write_data[6:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      read_data <= 32'h0000_0000;
    end else if (read_strobe) begin
      unique case (address)
        `OFS_MODE: read_data <= {30'h0, serial_mode_select};
        `OFS_INTDIV: read_data <= {16'h0, bitrate_integer_divisor};
        `OFS_FRAC: read_data <= {31'h0, bitrate_fraction_divisor};
        `OFS_CFG: read_data <= {25'h0, async_frame_config};
        `OFS_DATA: read_data <= rx_cnt != 3'h0 ? {22'h0, rx_mem[rx_rp]} : 32'h0;
        `OFS_STAT: read_data <= {24'h0, overrun, tx_state != TX_IDLE, rx_cnt, tx_cnt};
        default: read_data <= 32'h0000_0000;
      endcase
    end else begin
      read_data <= 32'h0000_0000;
    end
  end

  // Transmit buffer; writes to a full buffer are dropped
  assign tx_pop = enabled && tx_state == TX_IDLE && tx_cnt != 3'h0
    && (!handshake_enable || !clear_to_send_n); // see RULE19 see RULE18
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_wp <= 2'h0;
      tx_rp <= 2'h0;
      tx_cnt <= 3'h0;
    end else begin
      if (wr_data && tx_cnt != `FIFO_DEPTH) begin
        tx_mem[tx_wp] <= write_data[7:0]; // see RULE22
        tx_wp <= tx_wp + 2'h1;
      end
      if (tx_pop) tx_rp <= tx_rp + 2'h1;
      tx_cnt <= tx_cnt + {2'h0, wr_data && tx_cnt != `FIFO_DEPTH} - {2'h0, tx_pop};
    end
  end

  // Transmitter
  assign tx_end = tx_tick == 17'h0;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_state <= TX_IDLE;
      tx_tick <= 17'h0;
      tx_alt <= 1'b0;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      tx_second_stop <= 1'b0;
      serial_tx <= 1'b1;
    end else if (!enabled) begin
      tx_state <= TX_IDLE;
      serial_tx <= 1'b1; // see RULE14
    end else begin
      if (tx_state != TX_IDLE) tx_tick <= tx_end ? bit_len(!tx_alt) - 17'h1 : tx_tick - 17'h1;
      if (tx_state != TX_IDLE && tx_end) tx_alt <= !tx_alt; // see RULE24
      unique case (tx_state)
        TX_IDLE: if (tx_pop) begin
          tx_shift <= tx_mem[tx_rp];
          tx_state <= TX_START;
          tx_tick <= bit_len(tx_alt) - 17'h1;
          serial_tx <= 1'b0; // see RULE14 see RULE12
        end
        TX_START: if (tx_end) begin
          tx_state <= TX_DATA;
          tx_bit <= 3'h0;
          serial_tx <= tx_shift[0]; // see RULE12
        end
        TX_DATA: if (tx_end) begin
          if (tx_bit == {2'h3, eight_data_bits_sel}) begin // see RULE7
            tx_state <= parity_enable_bit ? TX_PAR : TX_STOP; // see RULE10
            serial_tx <= parity_enable_bit ? parity_of(tx_shift) : 1'b1;
            tx_second_stop <= two_stop_bits_sel;
          end else begin
            tx_bit <= tx_bit + 3'h1;
            serial_tx <= tx_shift[tx_bit + 3'h1];
          end
        end
        TX_PAR: if (tx_end) begin
          tx_state <= TX_STOP;
          serial_tx <= 1'b1;
        end
        TX_STOP: if (tx_end) begin
          if (tx_second_stop) tx_second_stop <= 1'b0; // see RULE8 see RULE13
          else tx_state <= TX_IDLE;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Receiver: a start must stay low for several cycles, then is checked again at mid-bit
  assign rx_end = rx_tick == 17'h0;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_state <= RX_IDLE;
      rx_tick <= 17'h0;
      rx_alt <= 1'b0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_par_err <= 1'b0;
      rx_low <= 3'h0;
    end else if (!enabled) begin
      rx_state <= RX_IDLE;
      rx_low <= 3'h0;
    end else begin
      if (rx_state != RX_IDLE) rx_tick <= rx_end ? bit_len(!rx_alt) - 17'h1 : rx_tick - 17'h1;
      if (rx_state != RX_IDLE && rx_end) rx_alt <= !rx_alt;
      unique case (rx_state)
        RX_IDLE: begin
          rx_low <= serial_rx ? 3'h0 : rx_low + 3'h1; // see RULE15
          if (!serial_rx && rx_low == `FILTER_LEN - 3'h1) begin
            rx_state <= RX_START; // see RULE23
            rx_tick <= {1'b0, bitrate_integer_divisor} - {14'h0, `FILTER_LEN} - 17'h1;
            rx_alt <= 1'b0;
          end
        end
        RX_START: if (rx_end) begin
          rx_low <= 3'h0;
          if (serial_rx) rx_state <= RX_IDLE; // see RULE15
          else begin
            rx_state <= RX_DATA;
            rx_bit <= 3'h0;
            rx_shift <= 8'h00;
          end
        end
        RX_DATA: if (rx_end) begin
          rx_shift[rx_bit] <= serial_rx; // see RULE12
          if (rx_bit == {2'h3, eight_data_bits_sel}) rx_state <= parity_enable_bit ? RX_PAR : RX_STOP;
          else rx_bit <= rx_bit + 3'h1;
          rx_par_err <= 1'b0;
        end
        RX_PAR: if (rx_end) begin
          rx_par_err <= serial_rx != parity_of(rx_shift); // see RULE16 see RULE10
          rx_state <= RX_STOP;
        end
        RX_STOP: if (rx_end) rx_state <= RX_IDLE; // see RULE9
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Receive buffer holds data with parity and frame flags
  assign rx_push = enabled && rx_state == RX_STOP && rx_end && rx_cnt != `FIFO_DEPTH;
  assign rx_full_drop = enabled && rx_state == RX_STOP && rx_end && rx_cnt == `FIFO_DEPTH;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_wp <= 2'h0;
      rx_rp <= 2'h0;
      rx_cnt <= 3'h0;
      overrun <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp] <= {!serial_rx, rx_par_err, rx_shift}; // see RULE16 see RULE22
        rx_wp <= rx_wp + 2'h1;
      end
      if (rd_data && rx_cnt != 3'h0) rx_rp <= rx_rp + 2'h1;
      rx_cnt <= rx_cnt + {2'h0, rx_push} - {2'h0, rd_data && rx_cnt != 3'h0};
      // Set wins over the clear by a status read
      if (rx_full_drop) overrun <= 1'b1;
      else if (read_strobe && address == `OFS_STAT) overrun <= 1'b0;
    end
  end

  // Request output: hardware or software level, idle high without flow control
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) request_to_send_n <= 1'b1;
    else if (!handshake_enable) request_to_send_n <= 1'b1; // see RULE18
    else if (auto_request_enable) request_to_send_n <= !(`FIFO_DEPTH - rx_cnt >= `RTS_ROOM); // see RULE20 see RULE17
    else request_to_send_n <= soft_request_level; // see RULE21
  end

  a_tx_idle_high: assert property (@(posedge clock) disable iff (!resetn)
    !enabled |=> serial_tx) else $error("tx not idle high"); // see RULE14
  a_cts_gates_start: assert property (@(posedge clock) disable iff (!resetn)
    tx_state == TX_IDLE && handshake_enable && clear_to_send_n |=> tx_state == TX_IDLE)
    else $error("started while clear high"); // see RULE19
  a_start_low: assert property (@(posedge clock) disable iff (!resetn)
    tx_state == TX_IDLE ##1 tx_state == TX_START |-> !serial_tx) else $error("start not low"); // see RULE12
  a_auto_rts: assert property (@(posedge clock) disable iff (!resetn)
    handshake_enable && auto_request_enable && rx_cnt >= 3'h3 && $stable(async_frame_config) |=> request_to_send_n)
    else $error("rts low with no room"); // see RULE20
  a_soft_rts: assert property (@(posedge clock) disable iff (!resetn)
    handshake_enable && !auto_request_enable |=> request_to_send_n == $past(soft_request_level))
    else $error("rts not software level"); // see RULE21
  a_glitch_reject: assert property (@(posedge clock) disable iff (!resetn)
    rx_state == RX_IDLE && serial_rx |=> rx_state == RX_IDLE) else $error("start on high line"); // see RULE15
  a_stop_high: assert property (@(posedge clock) disable iff (!resetn)
    tx_state == TX_STOP |-> serial_tx) else $error("stop bit low"); // see RULE8
  a_rx_depth: assert property (@(posedge clock) disable iff (!resetn)
    rx_cnt <= `FIFO_DEPTH && tx_cnt <= `FIFO_DEPTH) else $error("buffer overfilled"); // see RULE22
  c_tx_frame: cover property (@(posedge clock) tx_state == TX_STOP ##1 tx_state == TX_IDLE);
  c_rx_push: cover property (@(posedge clock) rx_push);
  c_overrun: cover property (@(posedge clock) rx_full_drop);
  c_par_err: cover property (@(posedge clock) rx_push && rx_par_err);
endmodule : serial_uart_frame_baud
`default_nettype wire

// ==== verif/remote_serial_peer.sv ====
// Purpose: Remote async serial peer that sends and samples frames
// Assumes: Fixed bit length in system clocks, frames given as bit vectors
// Notes: Sampling is at bit centres, so edge jitter of a cycle is tolerated
`timescale 1ns/1ps
`default_nettype none
module remote_serial_peer #(
  parameter int BIT_LEN = 16
) (
  input wire logic clock,
  input wire logic line_in,
  output logic line_out,
  output logic cts_n
);
  initial begin
    line_out = 1'b1;
    cts_n = 1'b1;
  end
  task automatic set_cts(input logic v);
    @(posedge clock);
    cts_n <= v;
  endtask : set_cts
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      line_out <= bits[i];
      repeat (BIT_LEN - 1) @(posedge clock);
    end
    @(posedge clock);
    line_out <= 1'b1;
  endtask : send
  task automatic glitch(input int len);
    @(posedge clock);
    line_out <= 1'b0;
    repeat (len) @(posedge clock);
    line_out <= 1'b1;
  endtask : glitch
  task automatic grab(input int n, output logic [11:0] bits, output logic ok);
    bits = 12'hfff;
    ok = 1'b0;
    for (int w = 0; w < 4000 && !ok; w++) begin
      @(posedge clock);
      #1;
      ok = (line_in === 1'b0);
    end
    if (ok) begin
      repeat (BIT_LEN / 2) @(posedge clock);
      for (int i = 0; i < n; i++) begin
        #1;
        bits[i] = line_in;
        repeat (BIT_LEN) @(posedge clock);
      end
    end
  endtask : grab
endmodule : remote_serial_peer
`default_nettype wire

// ==== verif/serial_uart_frame_baud_tb.sv ====
// Purpose: Self-checking bench of the async serial block
// Assumes: N=8, F=0, so one bit lasts 16 clocks
// Notes: Small divisor keeps the run short; fraction is checked by the length of a low run
`timescale 1ns/1ps
`default_nettype none
`include "uart_defs.svh"
module serial_uart_frame_baud_tb
  import uart_pkg::*;
;
  logic clock, resetn, write_strobe, read_strobe, serial_tx, serial_rx, request_to_send_n, clear_to_send_n, ok;
  logic [7:0] address, d;
  logic [31:0] write_data, read_data, r;
  logic [11:0] fb;
  logic [7:0] cfgs [6] = '{8'h02, 8'h00, 8'h0e, 8'h1c, 8'h1a, 8'h12};
  int err_total, compares, n;
  serial_uart_frame_baud i_dut (.clock(clock), .resetn(resetn), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data), .serial_tx(serial_tx),
    .serial_rx(serial_rx), .request_to_send_n(request_to_send_n), .clear_to_send_n(clear_to_send_n));
  remote_serial_peer #(.BIT_LEN(16)) i_peer (.clock(clock), .line_in(serial_tx), .line_out(serial_rx),
    .cts_n(clear_to_send_n));
  task automatic test_done;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    address <= a;
    write_data <= v;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1;
    v = read_data;
  endtask : rd
  function automatic logic [11:0] frame(input logic [7:0] dv, input logic [7:0] c, output int len);
    logic [11:0] f;
    int w;
    f = 12'hfff;
    w = c[`CFG_8BIT] ? 8 : 7;
    f[0] = 1'b0;
    for (int i = 0; i < w; i++)
      f[1 + i] = dv[i];
    len = 1 + w;
    if (c[`CFG_PAR]) begin
      f[len] = ^(dv & (w == 8 ? 8'hff : 8'h7f)) ^ c[`CFG_ODD];
      len++;
    end
    len += c[`CFG_2STP] ? 2 : 1;
    return f;
  endfunction : frame
  // A frame held back or lost ends the run, since later steps would only cascade
  task automatic tx_check(input logic [7:0] dv, input logic [7:0] c);
    logic [11:0] e;
    e = frame(dv, c, n);
    i_peer.grab(n, fb, ok);
    if (!ok) begin
      err_total++;
      test_done;
    end
    chk({20'h0, fb}, {20'h0, e}, "tx frame");
  endtask : tx_check
  task automatic hold_idle(input string what);
    ok = 1'b1;
    repeat (60) begin
      @(posedge clock);
      #1;
      ok = ok & (serial_tx === 1'b1);
    end
    chk({31'h0, ok}, 32'h1, what);
  endtask : hold_idle
  // Start plus seven zero data bits give eight low bit periods in a row
  task automatic low_run(input int exp, input string what);
    int len;
    len = 0;
    for (int w = 0; w < 400 && serial_tx !== 1'b0; w++) begin
      @(posedge clock);
      #1;
    end
    while (serial_tx === 1'b0 && len < 400) begin
      @(posedge clock);
      #1;
      len++;
    end
    chk(len, exp, what);
  endtask : low_run
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (90000) @(posedge clock);
    err_total++;
    test_done;
  end
  initial begin
    resetn = 1'b0;
    address = 8'h00;
    write_data = 32'h0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    #1;
    chk({31'h0, serial_tx}, 32'h1, "tx idle");
    chk({31'h0, request_to_send_n}, 32'h1, "rts idle");
    rd(`OFS_STAT, r);
    chk(r, 32'h0, "status reset");
    wr(`OFS_INTDIV, 32'h8);
    wr(`OFS_CFG, 32'h02);
    wr(`OFS_DATA, 32'h96);
    hold_idle("mode off");
    wr(`OFS_MODE, 32'h1);
    tx_check(8'h96, 8'h02);
    $display("test mode done");
    for (int i = 0; i < 6; i++) begin
      d = 8'ha5 + 8'(i * 29);
      wr(`OFS_CFG, {24'h0, cfgs[i]});
      wr(`OFS_DATA, {24'h0, d});
      tx_check(d, cfgs[i]);
      fb = frame(d, cfgs[i] & 8'hfb, n);
      i_peer.send(fb, n);
      rd(`OFS_DATA, r);
      chk(r & 32'h3ff, {24'h0, d & (cfgs[i][1] ? 8'hff : 8'h7f)}, "rx char");
    end
    chk({31'h0, request_to_send_n}, 32'h1, "rts no flow");
    $display("test frames done");
    wr(`OFS_CFG, 32'h0a);
    fb = frame(8'h4b, 8'h0a, n);
    fb[9] = ~fb[9];
    i_peer.send(fb, n);
    rd(`OFS_DATA, r);
    chk(r, 32'h14b, "parity flag");
    wr(`OFS_CFG, 32'h02);
    fb = frame(8'h7e, 8'h02, n);
    fb[9] = 1'b0;
    i_peer.send(fb, n);
    rd(`OFS_DATA, r);
    chk(r, 32'h27e, "frame flag");
    // A whole low stop bit may run on into a start; let that finish and drain it
    repeat (200) @(posedge clock);
    rd(`OFS_DATA, r);
    chk(r & 32'h200, 32'h0, "tail no frame flag");
    i_peer.glitch(2);
    repeat (40) @(posedge clock);
    rd(`OFS_STAT, r);
    chk(r & 32'h38, 32'h0, "glitch");
    $display("test errors done");
    wr(`OFS_CFG, 32'h22);
    @(posedge clock);
    #1;
    chk({31'h0, request_to_send_n}, 32'h0, "soft rts low");
    wr(`OFS_CFG, 32'h23);
    @(posedge clock);
    #1;
    chk({31'h0, request_to_send_n}, 32'h1, "soft rts high");
    wr(`OFS_DATA, 32'h3c);
    hold_idle("cts high");
    i_peer.set_cts(1'b0);
    tx_check(8'h3c, 8'h22);
    $display("test flow done");
    wr(`OFS_CFG, 32'h62);
    for (int k = 0; k < 5; k++) begin
      fb = frame(8'h10 + 8'(k), 8'h02, n);
      i_peer.send(fb, n);
      chk({31'h0, request_to_send_n}, {31'h0, k >= 2}, "auto rts");
    end
    rd(`OFS_STAT, r);
    chk(r & 32'hb8, 32'ha0, "overrun");
    rd(`OFS_STAT, r);
    chk(r & 32'hb8, 32'h20, "overrun clear");
    for (int k = 0; k < 4; k++) begin
      rd(`OFS_DATA, r);
      chk(r, 32'h10 + k, "drain");
    end
    rd(`OFS_DATA, r);
    chk(r, 32'h0, "empty read");
    $display("test buffer done");
    rd(`OFS_CFG, r);
    chk(r, 32'h62, "cfg readback");
    wr(`OFS_CFG, 32'h00);
    wr(`OFS_DATA, 32'h0);
    low_run(128, "bit run whole");
    wr(`OFS_FRAC, 32'h1);
    rd(`OFS_FRAC, r);
    chk(r, 32'h1, "fraction readback");
    rd(`OFS_INTDIV, r);
    chk(r, 32'h8, "divisor readback");
    rd(`OFS_MODE, r);
    chk(r, 32'h1, "mode readback");
    wr(`OFS_DATA, 32'h0);
    low_run(132, "bit run fraction");
    $display("test divisor done");
    test_done;
  end
endmodule : serial_uart_frame_baud_tb
`default_nettype wire
